/* verilog/loop_diag_exchange_remote.sv */
// Purpose: remote transceiver exchange-phase message flow controller
// Assumes: ticks, receive events and message bytes share i_clk
// Notes: message store gives octets combinationally, crc octets included
//
// Function
// R1: at exchange start send 64 marker symbols, then the first message
// R2: after each sent message hold 256 silent symbols, watching for ack
// R3: no or corrupted ack by silence end: marker again, same message
// R4: valid ack and messages left: marker again, next message
// R5: resends per message are capped; beyond cap invoke init reset
// R6: last message acked: wait in silence for first far-end message
// R7: answer a far-end message within 128 symbols of its end; a message ending in post-ack silence is answered only after that silence
// R8: error-free far-end message gets the positive acknowledgement
// R9: check value mismatch gets the negative acknowledgement
// R10: positive ack is octet 01010101 over 64 symbols, bit modulated
// R11: no check value is appended to the positive ack octet
// R12: negative ack is 64 silent symbols only
// R13: after either ack state send 256 silent symbols
// R14: central side goes idle or back to its marker in that silence
// R15: after that silence go idle or back to waiting, as central did
// R16: entering idle sets the link-off state
// R17: a repeated far-end message with same sequence is discarded
// R18: each bit is eight symbols, zero reference, one marker
// R19: octets in ascending order from sequence number, lsb first
// R20: keep last accepted sequence number, match means duplicate
`timescale 1ns/1ps
module loop_diag_exchange_remote
    import loop_diag_pkg::*;
#(
    parameter int NUM_MSG = 9,
    parameter int MAX_RESEND = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_sym_tick,
    input wire logic [8:0] i_tx_len,
    input wire logic [7:0] i_tx_data,
    input wire rx_msg_t i_rx_msg,
    input wire rx_ack_t i_rx_ack,
    input wire logic i_central_idle,
    input wire logic i_central_marker,
    output logic [3:0] o_tx_msg,
    output logic [8:0] o_tx_octet,
    output sym_out_t o_sym,
    output logic o_link_off,
    output logic o_init_reset,
    output logic o_rx_accept
);

    localparam logic [3:0] LAST_MSG = 4'(NUM_MSG - 1);
    localparam logic [3:0] RESEND_CAP = 4'(MAX_RESEND);

    typedef enum logic [3:0] {
        ST_OFF,
        ST_MARKER,
        ST_MESSAGE,
        ST_POST_SEND,
        ST_AWAIT,
        ST_ACK,
        ST_NACK,
        ST_POST_ACK,
        ST_IDLE,
        ST_FAILED
    } ex_state_t;

    ex_state_t state_reg;
    ex_state_t state_next;
    logic [15:0] sym_cnt_reg;
    logic [15:0] dur;
    logic has_dur;
    logic step_end;
    logic at_rest;
    logic start_go;
    logic [3:0] msg_idx_reg;
    logic [3:0] retry_reg;
    logic ack_ok_reg;
    logic ack_set;
    logic central_idle_reg;
    logic rx_pend_reg;
    logic rx_crc_ok_reg;
    logic rx_set;
    logic rx_check;
    logic rx_dup;
    logic [7:0] mod_byte;
    line_sym_t mod_sym;

    assign at_rest = (state_reg == ST_OFF) || (state_reg == ST_IDLE) ||
                     (state_reg == ST_FAILED);
    assign start_go = i_start && at_rest;

    always_comb begin
        has_dur = 1'b1;
        case (state_reg)
            ST_MARKER: dur = MARKER_SYMS; // R1
            ST_MESSAGE: dur = {1'b0, i_tx_len, OCTET_SYM_PAD}; // R18
            ST_POST_SEND: dur = POST_SEND_SYMS; // R2
            ST_ACK: dur = ACK_SYMS; // R10
            ST_NACK: dur = NACK_SYMS; // R12
            ST_POST_ACK: dur = POST_ACK_SYMS; // R13
            default: begin
                dur = 16'hffff;
                has_dur = 1'b0;
            end
        endcase
    end

    assign step_end = i_sym_tick && has_dur &&
                      (sym_cnt_reg == dur - 16'h0001);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF, ST_IDLE, ST_FAILED: begin
                if (i_start) begin
                    state_next = ST_MARKER; // R1
                end
            end
            ST_MARKER: begin
                if (step_end) begin
                    state_next = ST_MESSAGE; // R1
                end
            end
            ST_MESSAGE: begin
                if (step_end) begin
                    state_next = ST_POST_SEND; // R2
                end
            end
            ST_POST_SEND: begin
                if (step_end) begin
                    if (ack_ok_reg) begin
                        state_next = (msg_idx_reg == LAST_MSG) ?
                                     ST_AWAIT : ST_MARKER; // R4 R6
                    end else if (retry_reg == RESEND_CAP) begin
                        state_next = ST_FAILED; // R5
                    end else begin
                        state_next = ST_MARKER; // R3
                    end
                end
            end
            ST_AWAIT: begin
                // first tick after the message end, far inside the bound; a message that ended in the post-ack silence waits until that silence ends
                if (i_sym_tick && rx_pend_reg) begin
                    state_next = rx_crc_ok_reg ? ST_ACK : ST_NACK; // R7 R8 R9
                end
            end
            ST_ACK, ST_NACK: begin
                if (step_end) begin
                    state_next = ST_POST_ACK; // R13
                end
            end
            ST_POST_ACK: begin
                if (step_end) begin
                    state_next = central_idle_reg ? ST_IDLE : ST_AWAIT; // R15
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // no state loops onto itself, so any change restarts the count
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sym_cnt_reg <= 16'h0000;
        end else if (state_next != state_reg) begin
            sym_cnt_reg <= 16'h0000;
        end else if (i_sym_tick && has_dur) begin
            sym_cnt_reg <= sym_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            msg_idx_reg <= 4'h0;
            retry_reg <= 4'h0;
        end else if (start_go) begin
            msg_idx_reg <= 4'h0;
            retry_reg <= 4'h0;
        end else if (state_reg == ST_POST_SEND && step_end) begin
            if (ack_ok_reg && msg_idx_reg != LAST_MSG) begin
                msg_idx_reg <= msg_idx_reg + 4'h1; // R4
                retry_reg <= 4'h0;
            end else if (!ack_ok_reg) begin
                retry_reg <= retry_reg + 4'h1; // R5
            end
        end
    end

    // corrupted acks are simply not counted
    assign ack_set = (state_reg == ST_POST_SEND) && i_rx_ack.seen &&
                     i_rx_ack.ok; // R3

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_ok_reg <= 1'b0;
        end else if (ack_set) begin
            ack_ok_reg <= 1'b1; // R2
        end else if (state_next == ST_POST_SEND &&
                     state_reg != ST_POST_SEND) begin
            ack_ok_reg <= 1'b0;
        end
    end

    // silence from the central side counts as going back to its marker
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            central_idle_reg <= 1'b0;
        end else if (state_reg == ST_POST_ACK && i_central_idle) begin
            central_idle_reg <= 1'b1; // R14
        end else if ((state_reg == ST_POST_ACK && i_central_marker) ||
                     (state_next == ST_POST_ACK &&
                      state_reg != ST_POST_ACK)) begin
            central_idle_reg <= 1'b0; // R14
        end
    end

    // a message may end late in the post-ack silence as well
    assign rx_set = i_rx_msg.done &&
                    (state_reg == ST_AWAIT || state_reg == ST_POST_ACK);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_pend_reg <= 1'b0;
            rx_crc_ok_reg <= 1'b0;
        end else if (rx_set) begin
            rx_pend_reg <= 1'b1;
            rx_crc_ok_reg <= i_rx_msg.crc_ok; // R9
        end else if (start_go ||
                     (state_reg == ST_AWAIT && state_next != ST_AWAIT)) begin
            rx_pend_reg <= 1'b0;
        end
    end

    assign rx_check = rx_set && i_rx_msg.crc_ok;

    seq_dup_filter u_dup (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_clear(start_go),
        .i_check(rx_check),
        .i_seq(i_rx_msg.seq),
        .o_dup(rx_dup)
    );

    // a duplicate is still acknowledged, only its delivery is dropped
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_accept <= 1'b0;
        end else begin
            o_rx_accept <= rx_check && !rx_dup; // R17
        end
    end

    // ack octet stands alone, no check octets follow
    assign mod_byte = (state_reg == ST_ACK) ? ACK_OCTET : i_tx_data; // R10 R11

    line_sym_modulator u_mod (
        .i_byte(mod_byte),
        .i_bit_sel(sym_cnt_reg[OCTET_SEL_LSB-1:BIT_SEL_LSB]),
        .o_sym(mod_sym)
    );

    assign o_tx_msg = msg_idx_reg;
    assign o_tx_octet = sym_cnt_reg[OCTET_SEL_LSB+8:OCTET_SEL_LSB]; // R19

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sym <= '{valid: 1'b0, sym: SYM_QUIET};
        end else if (i_sym_tick) begin
            o_sym.valid <= 1'b1;
            case (state_reg)
                ST_MARKER: o_sym.sym <= SYM_MARKER; // R1
                ST_MESSAGE, ST_ACK: o_sym.sym <= mod_sym; // R10 R18
                default: o_sym.sym <= SYM_QUIET; // R12
            endcase
        end else begin
            o_sym.valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_link_off <= 1'b0;
        end else if (state_next == ST_IDLE && state_reg != ST_IDLE) begin
            o_link_off <= 1'b1; // R16
        end else if (start_go) begin
            o_link_off <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_init_reset <= 1'b0;
        end else begin
            o_init_reset <= (state_next == ST_FAILED) &&
                            (state_reg != ST_FAILED); // R5
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_start_marker;
        start_go |=> state_reg == ST_MARKER && sym_cnt_reg == 16'h0000;
    endproperty
    a_start_marker: assert property (p_start_marker) // R1
        else $error("exchange start did not enter marker");

    property p_marker_len;
        state_reg == ST_MARKER && i_sym_tick && sym_cnt_reg != 16'h003f
            |=> state_reg == ST_MARKER;
    endproperty
    a_marker_len: assert property (p_marker_len) // R1
        else $error("marker left before 64 symbols");

    property p_post_send_len;
        state_reg == ST_POST_SEND && i_sym_tick && sym_cnt_reg == 16'h00ff
            |=> state_reg != ST_POST_SEND;
    endproperty
    a_post_send_len: assert property (p_post_send_len) // R2
        else $error("post-send silence not 256 symbols");

    property p_resend_same;
        state_reg == ST_POST_SEND && step_end && !ack_ok_reg &&
            retry_reg != RESEND_CAP
            |=> state_reg == ST_MARKER && $stable(msg_idx_reg);
    endproperty
    a_resend_same: assert property (p_resend_same) // R3
        else $error("missing ack did not resend same message");

    property p_next_msg;
        state_reg == ST_POST_SEND && step_end && ack_ok_reg &&
            msg_idx_reg != LAST_MSG
            |=> state_reg == ST_MARKER &&
                msg_idx_reg == $past(msg_idx_reg) + 4'h1;
    endproperty
    a_next_msg: assert property (p_next_msg) // R4
        else $error("acked message did not advance");

    property p_cap;
        state_reg == ST_POST_SEND && step_end && !ack_ok_reg &&
            retry_reg == RESEND_CAP |=> o_init_reset ##1 !o_init_reset;
    endproperty
    a_cap: assert property (p_cap) // R5
        else $error("resend cap did not raise one init reset pulse");

    property p_await;
        state_reg == ST_POST_SEND && step_end && ack_ok_reg &&
            msg_idx_reg == LAST_MSG |=> state_reg == ST_AWAIT;
    endproperty
    a_await: assert property (p_await) // R6
        else $error("last ack did not lead to waiting");

    property p_answer;
        state_reg == ST_AWAIT && rx_pend_reg && i_sym_tick
            |=> (state_reg == ST_ACK) == $past(rx_crc_ok_reg) &&
                (state_reg == ST_ACK || state_reg == ST_NACK);
    endproperty
    a_answer: assert property (p_answer) // R7
        else $error("incoming message not answered correctly");

    property p_nack_quiet;
        state_reg == ST_NACK && i_sym_tick |=> o_sym.sym == SYM_QUIET;
    endproperty
    a_nack_quiet: assert property (p_nack_quiet) // R12
        else $error("negative ack sent a non-silent symbol");

    property p_ack_bits;
        state_reg == ST_ACK && i_sym_tick
            |=> o_sym.sym == ($past(sym_cnt_reg[3]) ?
                              SYM_REFERENCE : SYM_MARKER);
    endproperty
    a_ack_bits: assert property (p_ack_bits) // R10
        else $error("ack symbols do not carry 01010101");

    property p_end_choice;
        state_reg == ST_POST_ACK && step_end
            |=> state_reg == ($past(central_idle_reg) ? ST_IDLE : ST_AWAIT);
    endproperty
    a_end_choice: assert property (p_end_choice) // R15
        else $error("post-ack silence ended in wrong state");

    property p_link_off;
        state_reg == ST_IDLE |-> o_link_off;
    endproperty
    a_link_off: assert property (p_link_off) // R16
        else $error("idle without link-off");

    property p_no_dup;
        rx_check && rx_dup |=> !o_rx_accept;
    endproperty
    a_no_dup: assert property (p_no_dup) // R17
        else $error("duplicate message was delivered");

    c_resend: cover property (state_reg == ST_POST_SEND && step_end &&
                              !ack_ok_reg && retry_reg != RESEND_CAP);
    c_idle: cover property (state_reg == ST_POST_ACK ##1
                            state_reg == ST_IDLE);
    c_nack: cover property (state_reg == ST_NACK);
    c_dup: cover property (rx_check && rx_dup);

endmodule : loop_diag_exchange_remote

/* verilog/loop_diag_pkg.sv */
// Purpose: shared constants and types for the loop diagnostics exchange
// Assumes: all durations are counted in line symbol periods
// Notes: symbol rate is set by the modem core through a symbol tick
package loop_diag_pkg;

    // clock of the exchange logic
    localparam int CLK_PERIOD_NS = 4;

    localparam int SYM_CNT_W = 16;

    // state durations in symbols
    localparam logic [15:0] MARKER_SYMS = 16'h0040;
    localparam logic [15:0] POST_SEND_SYMS = 16'h0100;
    localparam logic [15:0] ACK_SYMS = 16'h0040;
    localparam logic [15:0] NACK_SYMS = 16'h0040;
    localparam logic [15:0] POST_ACK_SYMS = 16'h0100;
    localparam logic [15:0] RESP_LIMIT_SYMS = 16'h0080;

    // eight symbols per bit, eight bits per octet
    localparam int BIT_SEL_LSB = 3;
    localparam int OCTET_SEL_LSB = 6;
    localparam logic [5:0] OCTET_SYM_PAD = 6'h00;

    localparam logic [7:0] ACK_OCTET = 8'h55;
    localparam logic [7:0] SEQ_RESET = 8'h00;

    typedef enum logic [1:0] {
        SYM_QUIET,
        SYM_REFERENCE,
        SYM_MARKER
    } line_sym_t;

    typedef struct packed {
        logic valid;
        line_sym_t sym;
    } sym_out_t;

    typedef struct packed {
        logic done;
        logic crc_ok;
        logic [7:0] seq;
    } rx_msg_t;

    typedef struct packed {
        logic seen;
        logic ok;
    } rx_ack_t;

endpackage : loop_diag_pkg

/* verilog/line_sym_modulator.sv */
// Purpose: maps one octet to its line symbols, eight symbols per bit
// Assumes: symbol index counts within the octet, lsb first
// Notes: purely combinational, caller registers the result
`timescale 1ns/1ps
module line_sym_modulator
    import loop_diag_pkg::*;
(
    input wire logic [7:0] i_byte,
    input wire logic [2:0] i_bit_sel,
    output line_sym_t o_sym
);

    logic bit_val;

    assign bit_val = i_byte[i_bit_sel]; // R19

    // one is marker, zero is reference
    assign o_sym = bit_val ? SYM_MARKER : SYM_REFERENCE; // R18

endmodule : line_sym_modulator

/* verilog/seq_dup_filter.sv */
// Purpose: remembers the last accepted far-end sequence number
// Assumes: i_check pulses once per error-free incoming message
// Notes: cleared at the start of each exchange
`timescale 1ns/1ps
module seq_dup_filter
    import loop_diag_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_clear,
    input wire logic i_check,
    input wire logic [7:0] i_seq,
    output logic o_dup
);

    logic [7:0] seq_reg;
    logic valid_reg;

    // duplicate only after a first message was taken
    assign o_dup = valid_reg && (i_seq == seq_reg); // R20

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            seq_reg <= SEQ_RESET;
            valid_reg <= 1'b0;
        end else if (i_clear) begin
            seq_reg <= SEQ_RESET;
            valid_reg <= 1'b0;
        end else if (i_check && !o_dup) begin
            seq_reg <= i_seq; // R20
            valid_reg <= 1'b1;
        end
    end

endmodule : seq_dup_filter

/* bench/central_far_model.sv */
// Purpose: behavioural central transceiver facing the remote exchange
// Assumes: its events are one-cycle pulses launched at the falling edge
// Notes: message decode is abstracted to done, check result and sequence
`timescale 1ns/1ps
module central_far_model
    import loop_diag_pkg::*;
(
    input wire logic i_clk,
    output rx_msg_t o_rx_msg,
    output rx_ack_t o_rx_ack,
    output logic o_central_idle,
    output logic o_central_marker
);
    initial begin
        o_rx_msg = '0;
        o_rx_ack = '0;
        o_central_idle = 1'b0;
        o_central_marker = 1'b0;
    end

    // dly lets the ack come early or late; ok low is a corrupted ack
    task automatic send_ack(input int dly, input logic ok);
        repeat (dly) @(negedge i_clk);
        o_rx_ack <= '{seen: 1'b1, ok: ok};
        @(negedge i_clk);
        o_rx_ack <= '0;
    endtask : send_ack

    // end of one far-end message; fields cleared after the pulse
    task automatic send_msg(input logic crc_ok, input logic [7:0] seq);
        // launch off the sampling edge so the pulse spans one rising edge
        @(negedge i_clk);
        o_rx_msg <= '{done: 1'b1, crc_ok: crc_ok, seq: seq};
        @(negedge i_clk);
        o_rx_msg <= '0;
    endtask : send_msg

    // idle when nothing is left to send, else back to its marker
    task automatic central_state(input int dly, input logic idle);
        repeat (dly) @(negedge i_clk);
        o_central_idle <= idle;
        o_central_marker <= !idle;
        @(negedge i_clk);
        o_central_idle <= 1'b0;
        o_central_marker <= 1'b0;
    endtask : central_state
endmodule : central_far_model

/* bench/loop_diag_exchange_remote_tb_top.sv */
// Purpose: self-checking bench for the remote exchange flow controller
// Assumes: symbol tick every fourth clock, short messages of 1 and 2 octets
// Notes: resend cap of 1 keeps the failure path short
`timescale 1ns/1ps
module loop_diag_exchange_remote_tb_top;
    import loop_diag_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic sym_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic [8:0] tx_len;
    logic [7:0] tx_data;
    rx_msg_t rx_msg;
    rx_ack_t rx_ack;
    logic c_idle;
    logic c_marker;
    logic [3:0] tx_msg;
    logic [8:0] tx_octet;
    sym_out_t sym;
    logic link_off;
    logic init_reset;
    logic rx_accept;
    int err_count = 0;
    int total_checks = 0;
    int acc_cnt = 0;
    int init_cnt = 0;

    always #2 clk = ~clk;

    // tick count free-runs; three idle clocks between ticks
    always @(negedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        sym_tick <= (tick_cnt == 2'h0);
    end

    always @(posedge clk) begin
        if (rx_accept === 1'b1) acc_cnt++;
        if (init_reset === 1'b1) init_cnt++;
    end

    // message store: octet value tied to its message and position
    assign tx_len = (tx_msg == 4'h0) ? 9'h001 : 9'h002;
    assign tx_data = 8'h3c ^ {tx_msg, tx_octet[3:0]};

    loop_diag_exchange_remote #(.NUM_MSG(2), .MAX_RESEND(1))
        u_loop_diag_exchange_remote (
        .i_clk(clk), .i_rstn(rstn), .i_start(start),
        .i_sym_tick(sym_tick), .i_tx_len(tx_len), .i_tx_data(tx_data),
        .i_rx_msg(rx_msg), .i_rx_ack(rx_ack), .i_central_idle(c_idle),
        .i_central_marker(c_marker), .o_tx_msg(tx_msg),
        .o_tx_octet(tx_octet), .o_sym(sym), .o_link_off(link_off),
        .o_init_reset(init_reset), .o_rx_accept(rx_accept));

    central_far_model u_central_far_model (
        .i_clk(clk), .o_rx_msg(rx_msg), .o_rx_ack(rx_ack),
        .o_central_idle(c_idle), .o_central_marker(c_marker));

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [8:0] got,
                         input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : check

    // bounded wait for the next symbol strobe
    task automatic next_sym(output line_sym_t s);
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sym.valid !== 1'b1 && n < 40);
        if (sym.valid !== 1'b1) begin
            check("symbol strobe", 9'h000, 9'h001);
            end_sim();
        end
        s = sym.sym;
    endtask : next_sym

    task automatic expect_run(input int n, input line_sym_t e,
                              input string what);
        line_sym_t s;
        for (int i = 0; i < n; i++) begin
            next_sym(s);
            check(what, {7'h0, s}, {7'h0, e});
        end
    endtask : expect_run

    // lsb first, eight symbols per bit
    task automatic expect_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            expect_run(8, b[i] ? SYM_MARKER : SYM_REFERENCE, "bit");
        end
    endtask : expect_byte

    task automatic tx_frame(input int m);
        expect_run(64, SYM_MARKER, "marker");
        check("msg index", {5'h0, tx_msg}, m[8:0]);
        for (int k = 0; k <= m; k++) begin
            expect_byte(8'h3c ^ {m[3:0], k[3:0]});
        end
    endtask : tx_frame

    task automatic pulse_start();
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask : pulse_start

    task automatic sc_reset();
        check("link off", {8'h0, link_off}, 9'h000);
        check("sym", {6'h0, sym}, 9'h000);
        check("init reset", {8'h0, init_reset}, 9'h000);
    endtask : sc_reset

    // no ack twice: one resend, then the cap trips
    task automatic sc_resend_cap();
        pulse_start();
        tx_frame(0);
        expect_run(256, SYM_QUIET, "post send");
        tx_frame(0);
        expect_run(256, SYM_QUIET, "post send");
        repeat (8) @(posedge clk);
        check("init resets", init_cnt[8:0], 9'h001);
    endtask : sc_resend_cap

    // corrupted ack, prompt ack, late ack, then waiting for far end
    task automatic sc_send_ok();
        pulse_start();
        tx_frame(0);
        fork
            u_central_far_model.send_ack(200, 1'b0);
            expect_run(256, SYM_QUIET, "post send");
        join
        tx_frame(0);
        fork
            u_central_far_model.send_ack(8, 1'b1);
            expect_run(256, SYM_QUIET, "post send");
        join
        tx_frame(1);
        fork
            u_central_far_model.send_ack(900, 1'b1);
            expect_run(256, SYM_QUIET, "post send");
        join
        expect_run(20, SYM_QUIET, "await");
        check("init resets", init_cnt[8:0], 9'h001);
    endtask : sc_send_ok

    // good, duplicate and corrupted far-end messages, then idle
    task automatic sc_far_msgs();
        int a0 = acc_cnt;
        u_central_far_model.send_msg(1'b1, 8'h05);
        // last waiting symbol goes out on the tick that starts the answer
        expect_run(1, SYM_QUIET, "await");
        expect_byte(8'h55);
        fork
            u_central_far_model.central_state(100, 1'b0);
            expect_run(256, SYM_QUIET, "post ack");
        join
        check("accepts", acc_cnt[8:0], a0[8:0] + 9'h001);
        expect_run(4, SYM_QUIET, "await");
        check("link off", {8'h0, link_off}, 9'h000);
        u_central_far_model.send_msg(1'b1, 8'h05);
        expect_run(1, SYM_QUIET, "await");
        expect_byte(8'h55);
        fork
            u_central_far_model.central_state(100, 1'b0);
            expect_run(256, SYM_QUIET, "post ack");
        join
        check("dup accepts", acc_cnt[8:0], a0[8:0] + 9'h001);
        expect_run(4, SYM_QUIET, "await");
        u_central_far_model.send_msg(1'b0, 8'h06);
        expect_run(1, SYM_QUIET, "await");
        fork
            u_central_far_model.central_state(600, 1'b1);
            expect_run(320, SYM_QUIET, "nack");
        join
        repeat (3) @(posedge clk);
        check("link off", {8'h0, link_off}, 9'h001);
        check("bad accepts", acc_cnt[8:0], a0[8:0] + 9'h001);
    endtask : sc_far_msgs

    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        sc_reset();
        sc_resend_cap();
        sc_send_ok();
        sc_far_msgs();
        end_sim();
    end
endmodule : loop_diag_exchange_remote_tb_top
